// [shared/fcp_defines.vh]
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define FCP_IDX_CTRL_A 8'hcc
`define FCP_IDX_CTRL_B 8'hce
`define FCP_IDX_DUTY4 8'hcf
`define FCP_IDX_PERIOD 8'hd0
`define FCP_IDX_DUTY0 8'hd1
`define FCP_IDX_DUTY1 8'hd2
`define FCP_IDX_DUTY2 8'hdd
`define FCP_IDX_DUTY3 8'hde
`define FCP_IDX_COUNT 8'hdf

// Internal select codes produced by the address decoder.
`define FCP_SEL_CTRL_A 4'h0
`define FCP_SEL_CTRL_B 4'h1
`define FCP_SEL_PERIOD 4'h2
`define FCP_SEL_DUTY0 4'h3
`define FCP_SEL_DUTY1 4'h4
`define FCP_SEL_DUTY2 4'h5
`define FCP_SEL_DUTY3 4'h6
`define FCP_SEL_DUTY4 4'h7
`define FCP_SEL_COUNT 4'h8

// Control field positions: run and pin drive select bits per channel.
`define FCP_A_RUN0 0
`define FCP_A_RUN1 1
`define FCP_A_PIN0 2
`define FCP_A_PIN1 3
`define FCP_A_RUN2 4
`define FCP_A_RUN3 5
`define FCP_A_PIN2 6
`define FCP_A_PIN3 7
`define FCP_B_RUN4 0
`define FCP_B_PIN4 2

`define FCP_REG_RESET 8'h00
`define FCP_COUNT_LAST 8'hfe
`define FCP_RESP_OKAY 2'b00
`define FCP_RESP_SLVERR 2'b10

`endif

// [core/fcp_pwm_unit.v]
// Summary of operation
// RULE1: Five channels drive port pins three to seven.
// RULE2: One shared 8-bit prescaler clocks shared counter.
// RULE3: Prescaler divides by period plus one.
// RULE4: Duty at or below counter drives zero.
// RULE5: Duty above counter drives one.
// RULE6: Each channel runs only while enabled.
// RULE7: Pin shows waveform only when selected.
// RULE8: Duty 00 constant low, FF constant high.
// RULE9: New duty value takes effect immediately.
// RULE10: Counter steps per prescaler pulse, wraps 0-254.
// RULE11: All registers reset to zero, pins GPIO.
`include "fcp_defines.vh"

module fcp_pwm_unit #(
  parameter CHANNELS = 5,
  parameter ADDR_W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [CHANNELS-1:0] gpio_level,
  output wire [CHANNELS-1:0] pin_level,
  output wire [CHANNELS-1:0] pin_drive_select
);

  // Returns {hit, select code} for a byte address.
  function [4:0] fcp_decode;
    input [ADDR_W-1:0] addr;
    begin
      fcp_decode = {1'b0, 4'h0};
      if (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) begin
        case (addr[9:2])
          `FCP_IDX_CTRL_A: fcp_decode = {1'b1, `FCP_SEL_CTRL_A};
          `FCP_IDX_CTRL_B: fcp_decode = {1'b1, `FCP_SEL_CTRL_B};
          `FCP_IDX_PERIOD: fcp_decode = {1'b1, `FCP_SEL_PERIOD};
          `FCP_IDX_DUTY0: fcp_decode = {1'b1, `FCP_SEL_DUTY0};
          `FCP_IDX_DUTY1: fcp_decode = {1'b1, `FCP_SEL_DUTY1};
          `FCP_IDX_DUTY2: fcp_decode = {1'b1, `FCP_SEL_DUTY2};
          `FCP_IDX_DUTY3: fcp_decode = {1'b1, `FCP_SEL_DUTY3};
          `FCP_IDX_DUTY4: fcp_decode = {1'b1, `FCP_SEL_DUTY4};
          `FCP_IDX_COUNT: fcp_decode = {1'b1, `FCP_SEL_COUNT};
          default: fcp_decode = {1'b0, 4'h0};
        endcase
      end
    end
  endfunction

  // Maps a channel number to the select code of its duty register.
  function [3:0] fcp_duty_sel;
    input integer ch;
    begin
      case (ch)
        0: fcp_duty_sel = `FCP_SEL_DUTY0;
        1: fcp_duty_sel = `FCP_SEL_DUTY1;
        2: fcp_duty_sel = `FCP_SEL_DUTY2;
        3: fcp_duty_sel = `FCP_SEL_DUTY3;
        4: fcp_duty_sel = `FCP_SEL_DUTY4;
        default: fcp_duty_sel = `FCP_SEL_COUNT;
      endcase
    end
  endfunction

  // Picks a channel's run bit out of the two control registers.
  function fcp_run_bit;
    input integer ch;
    input [7:0] ctrl_a;
    input [7:0] ctrl_b;
    begin
      case (ch)
        0: fcp_run_bit = ctrl_a[`FCP_A_RUN0];
        1: fcp_run_bit = ctrl_a[`FCP_A_RUN1];
        2: fcp_run_bit = ctrl_a[`FCP_A_RUN2];
        3: fcp_run_bit = ctrl_a[`FCP_A_RUN3];
        4: fcp_run_bit = ctrl_b[`FCP_B_RUN4];
        default: fcp_run_bit = 1'b0;
      endcase
    end
  endfunction

  // Picks a channel's pin drive select bit out of the two control registers.
  function fcp_pin_bit;
    input integer ch;
    input [7:0] ctrl_a;
    input [7:0] ctrl_b;
    begin
      case (ch)
        0: fcp_pin_bit = ctrl_a[`FCP_A_PIN0];
        1: fcp_pin_bit = ctrl_a[`FCP_A_PIN1];
        2: fcp_pin_bit = ctrl_a[`FCP_A_PIN2];
        3: fcp_pin_bit = ctrl_a[`FCP_A_PIN3];
        4: fcp_pin_bit = ctrl_b[`FCP_B_PIN4];
        default: fcp_pin_bit = 1'b0;
      endcase
    end
  endfunction

  reg awready_reg;
  reg wready_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [7:0] w_data_reg;
  reg w_lane0_reg;

  reg [7:0] ctrl_a_reg;
  reg [7:0] ctrl_b_reg;
  reg [7:0] period_reg;
  reg [7:0] duty_reg [0:CHANNELS-1];
  reg [7:0] prescale_reg;
  reg [7:0] count_reg;
  reg [CHANNELS-1:0] pin_level_reg;
  reg [CHANNELS-1:0] pin_sel_reg;

  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [4:0] wr_dec = fcp_decode(aw_addr_reg);
  wire [4:0] rd_dec = fcp_decode(s_axi_araddr);
  wire wr_ok = wr_dec[4] && (wr_dec[3:0] != `FCP_SEL_COUNT);

  // A cleared lane 0 strobe leaves the register alone but still answers OKAY.
  wire lane_wr = do_write && wr_ok && w_lane0_reg;
  wire [CHANNELS-1:0] ch_run;
  wire [CHANNELS-1:0] ch_pin;
  wire [CHANNELS-1:0] ch_wave;
  wire any_run = |ch_run;
  reg [7:0] prescale_next;
  reg [7:0] count_next;
  reg [31:0] rdata_next;
  reg [CHANNELS-1:0] pin_level_next;
  reg [CHANNELS-1:0] pin_sel_next;
  wire step = any_run && (prescale_reg == period_reg);

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pin_level = pin_level_reg;
  assign pin_drive_select = pin_sel_reg;

  // Write channel: address and data are held until both are present.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `FCP_RESP_OKAY;
    end else begin
      if (!aw_full_reg && !bvalid_reg && !awready_reg) begin
        awready_reg <= 1'b1;
      end
      if (!w_full_reg && !bvalid_reg && !wready_reg) begin
        wready_reg <= 1'b1;
      end
      if (s_axi_awvalid && awready_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data for the address on offer; unmapped addresses read as zero.
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_dec[4]) begin
      case (rd_dec[3:0])
        `FCP_SEL_CTRL_A: rdata_next = {24'h000000, ctrl_a_reg};
        `FCP_SEL_CTRL_B: rdata_next = {24'h000000, ctrl_b_reg};
        `FCP_SEL_PERIOD: rdata_next = {24'h000000, period_reg};
        `FCP_SEL_DUTY0: rdata_next = {24'h000000, duty_reg[0]};
        `FCP_SEL_DUTY1: rdata_next = {24'h000000, duty_reg[1]};
        `FCP_SEL_DUTY2: rdata_next = {24'h000000, duty_reg[2]};
        `FCP_SEL_DUTY3: rdata_next = {24'h000000, duty_reg[3]};
        `FCP_SEL_DUTY4: rdata_next = {24'h000000, duty_reg[4]};
        `FCP_SEL_COUNT: rdata_next = {24'h000000, count_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance.
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `FCP_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (!rvalid_reg && !arready_reg) begin
        arready_reg <= 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_dec[4] ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
        rdata_reg <= rdata_next;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Control registers; only byte lane 0 carries data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg <= `FCP_REG_RESET; // RULE11
      ctrl_b_reg <= `FCP_REG_RESET; // RULE11
      period_reg <= `FCP_REG_RESET; // RULE11
    end else if (lane_wr) begin
      case (wr_dec[3:0])
        `FCP_SEL_CTRL_A: ctrl_a_reg <= w_data_reg;
        `FCP_SEL_CTRL_B: ctrl_b_reg <= w_data_reg;
        `FCP_SEL_PERIOD: period_reg <= w_data_reg;
        default: ctrl_a_reg <= ctrl_a_reg;
      endcase
    end
  end

  // Shared prescaler and counter; both rest at zero while no channel runs.
  always @* begin
    prescale_next = prescale_reg + 8'h01; // RULE2
    count_next = count_reg;
    if (!any_run) begin
      prescale_next = 8'h00;
      count_next = 8'h00;
    end else if (step) begin
      // The prescaler spans period plus one clocks before the counter moves.
      prescale_next = 8'h00; // RULE3
      if (count_reg == `FCP_COUNT_LAST) begin
        count_next = 8'h00; // RULE10
      end else begin
        count_next = count_reg + 8'h01; // RULE10
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      prescale_reg <= 8'h00;
      count_reg <= 8'h00;
    end else begin
      prescale_reg <= prescale_next;
      count_reg <= count_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
      assign ch_run[gi] = fcp_run_bit(gi, ctrl_a_reg, ctrl_b_reg); // RULE6
      assign ch_pin[gi] = fcp_pin_bit(gi, ctrl_a_reg, ctrl_b_reg); // RULE7
      // The live duty register feeds the comparator, so a write acts at once.
      assign ch_wave[gi] = ch_run[gi] && (duty_reg[gi] > count_reg); // RULE4 RULE5 RULE8 RULE9
    end
  endgenerate

  // Duty registers; only byte lane 0 carries data.
  always @(posedge aclk) begin : duty_write
    integer k;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (!aresetn) begin
        duty_reg[k] <= `FCP_REG_RESET; // RULE11
      end else if (lane_wr && wr_dec[3:0] == fcp_duty_sel(k)) begin
        duty_reg[k] <= w_data_reg;
      end
    end
  end

  // Each shared pin shows its channel's waveform when selected, else the port latch.
  always @* begin : pin_mux
    integer k;
    k = 0;
    pin_level_next = {CHANNELS{1'b0}};
    pin_sel_next = {CHANNELS{1'b0}};
    for (k = 0; k < CHANNELS; k = k + 1) begin
      pin_sel_next[k] = ch_pin[k]; // RULE7
      if (ch_pin[k]) begin
        pin_level_next[k] = ch_wave[k]; // RULE1 RULE7
      end else begin
        pin_level_next[k] = gpio_level[k]; // RULE7
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_level_reg <= {CHANNELS{1'b0}}; // RULE11
      pin_sel_reg <= {CHANNELS{1'b0}}; // RULE11
    end else begin
      pin_level_reg <= pin_level_next;
      pin_sel_reg <= pin_sel_next;
    end
  end

endmodule // fcp_pwm_unit

// [dv/fcp_pwm_unit_props.sv]
module fcp_pwm_unit_props #(
  parameter CHANNELS = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [CHANNELS-1:0] gpio_level,
  input wire [CHANNELS-1:0] pin_level,
  input wire [CHANNELS-1:0] pin_drive_select
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_reset_clear:
    assert property ($rose(aresetn) |-> pin_level == 0 && pin_drive_select == 0)
    else $error("pins not clear after reset");
  chk_gpio_pass:
    assert property ($past(aresetn, 2) && $stable(pin_drive_select) |->
      ((pin_level ^ $past(gpio_level)) & ~pin_drive_select) == 0)
    else $error("unselected pin does not follow port latch");
  chk_select_cause:
    assert property ($changed(pin_drive_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin select changed without a write");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready not dropped");
  chk_w_drop: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data ready not dropped");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // fcp_pwm_unit_props

bind fcp_pwm_unit fcp_pwm_unit_props #(.CHANNELS(CHANNELS)) chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .gpio_level, .pin_level,
  .pin_drive_select);

// [dv/fcp_pwm_unit_tb.sv]
`include "fcp_defines.vh"
module fcp_pwm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0] ws = 4'h1;
  logic [4:0] gpio = 0;
  wire awr, wrdy, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [4:0] pin, sel;
  int mismatches = 0, checked = 0, cycles = 0;
  fcp_pwm_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .gpio_level(gpio), .pin_level(pin),
    .pin_drive_select(sel));
  initial forever #10 aclk = ~aclk;
  task automatic cmp(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wreg(input [7:0] i, d, input [1:0] r = `FCP_RESP_OKAY);
    awa <= {2'h0, i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    cmp("bresp", {30'h0, r}, {30'h0, br});
  endtask
  task automatic rreg(input [7:0] i, d, input [1:0] r = `FCP_RESP_OKAY);
    ara <= {2'h0, i, 2'h0};
    arv <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (!rv);
    cmp("rdata", {24'h0, d}, rdat);
    cmp("rresp", {30'h0, r}, {30'h0, rr});
  endtask
  // Samples settled outputs mid-cycle, then returns on a rising edge for the next drive.
  task automatic look(input [4:0] s, p);
    @(negedge aclk);
    cmp("select", {27'h0, s}, {27'h0, sel});
    cmp("pin", {27'h0, p}, {27'h0, pin});
    @(posedge aclk);
  endtask
  task automatic t_reset;
    logic [7:0] ix[9] = '{`FCP_IDX_CTRL_A, `FCP_IDX_CTRL_B, `FCP_IDX_PERIOD, `FCP_IDX_DUTY0,
      `FCP_IDX_DUTY1, `FCP_IDX_DUTY2, `FCP_IDX_DUTY3, `FCP_IDX_DUTY4, `FCP_IDX_COUNT};
    foreach (ix[k]) rreg(ix[k], 8'h00);
    look(5'h00, 5'h00);
    $display("reset values test done");
  endtask
  task automatic t_sel;
    gpio <= 5'h15;
    wreg(`FCP_IDX_CTRL_A, 8'hcc);
    wreg(`FCP_IDX_CTRL_B, 8'h04);
    rreg(`FCP_IDX_CTRL_B, 8'h04);
    look(5'h1f, 5'h00);
    wreg(`FCP_IDX_CTRL_A, 8'h00);
    wreg(`FCP_IDX_CTRL_B, 8'h00);
    look(5'h00, 5'h15);
    $display("pin select test done");
  endtask
  task automatic t_const;
    int bad = 0;
    gpio <= 5'h1f;
    wreg(`FCP_IDX_DUTY0, 8'h00);
    wreg(`FCP_IDX_DUTY1, 8'hff);
    wreg(`FCP_IDX_CTRL_A, 8'h0f);
    repeat (300) begin
      @(negedge aclk);
      if (pin !== 5'h1e || sel !== 5'h03) bad++;
    end
    @(posedge aclk);
    cmp("const level errors", 32'h0, bad);
    wreg(`FCP_IDX_CTRL_A, 8'h00);
    $display("constant level test done");
  endtask
  task automatic t_duty;
    int hi = 0;
    wreg(`FCP_IDX_PERIOD, 8'h01);
    wreg(`FCP_IDX_DUTY4, 8'h80);
    wreg(`FCP_IDX_CTRL_B, 8'h05);
    // One full period of (1+1)*255 cycles holds exactly 128 counts below the duty.
    repeat (510) begin
      @(negedge aclk);
      hi += pin[4];
    end
    @(posedge aclk);
    cmp("high cycles", 32'd256, hi);
    wreg(`FCP_IDX_PERIOD, 8'hff);
    wreg(`FCP_IDX_DUTY4, 8'hff);
    look(5'h10, 5'h1f);
    wreg(`FCP_IDX_DUTY4, 8'h00);
    look(5'h10, 5'h0f);
    $display("duty test done");
  endtask
  task automatic t_bad;
    wreg(8'h00, 8'h5a, `FCP_RESP_SLVERR);
    rreg(8'h00, 8'h00, `FCP_RESP_SLVERR);
    wreg(`FCP_IDX_COUNT, 8'h01, `FCP_RESP_SLVERR);
    ws <= 4'h0;
    wreg(`FCP_IDX_DUTY4, 8'h77);
    ws <= 4'h1;
    rreg(`FCP_IDX_DUTY4, 8'h00);
    $display("error response test done");
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_sel();
    t_const();
    t_duty();
    t_bad();
    complete_run();
  end
endmodule // fcp_pwm_unit_tb
